// File: rtl/dwsb_map.svh
// Purpose: Constants of the dual wiper setting bank
// Assumes: Included by bare name; guard stops double inclusion
// Notes:   Command byte layout is op[7:5], pot[4], slot[3:2]
`ifndef DWSB_MAP_SVH
`define DWSB_MAP_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define DWSB_WIPER_W     6
`define DWSB_TAPS        64
`define DWSB_POTS        2
`define DWSB_SLOTS       4
`define DWSB_SLOT_W      2

// ----------------------------------------------------------------
// Bus framing
// ----------------------------------------------------------------
`define DWSB_BIT_ACK     4'h8
`define DWSB_BIT_MSB     3'h7
`define DWSB_TYPE_HI     7
`define DWSB_TYPE_LO     5
`define DWSB_PINS_HI     4
`define DWSB_PINS_LO     1
`define DWSB_RW_BIT      0

// ----------------------------------------------------------------
// Command byte fields and opcodes
// ----------------------------------------------------------------
`define DWSB_OP_HI       7
`define DWSB_OP_LO       5
`define DWSB_POT_BIT     4
`define DWSB_SLOT_HI     3
`define DWSB_SLOT_LO     2
`define DWSB_STEP_BIT    0
`define DWSB_OP_WR_WIPER  3'h0
`define DWSB_OP_RD_WIPER  3'h1
`define DWSB_OP_WR_STORED 3'h2
`define DWSB_OP_RD_STORED 3'h3
`define DWSB_OP_RECALL    3'h4
`define DWSB_OP_SAVE      3'h5
`define DWSB_OP_INCDEC    3'h6
`define DWSB_OP_RSVD      3'h7
`define DWSB_WIPER_MAX    6'h3f
`define DWSB_WIPER_MIN    6'h00

`endif

// File: rtl/dwsb_pkg.sv
// Purpose: Types of the dual wiper setting bank
// Assumes: dwsb_map.svh gives the widths
// Notes:   Both clock domains keep their state in one struct each
`include "dwsb_map.svh"
package dwsb_pkg;

	typedef logic [`DWSB_WIPER_W-1:0] dwsb_wiper_t;
	typedef logic [`DWSB_TAPS-1:0]    dwsb_tap_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_DATA,
		ST_TX,
		ST_WAIT
	} dwsb_state_e;

	typedef struct packed {
		dwsb_state_e                                  state;
		logic [3:0]                                   bit_cnt;
		logic                                         scl_d;
		logic                                         sda_d;
		logic                                         boot;
		logic [7:0]                                   cmd;
		logic [7:0]                                   tx;
		logic                                         sda_lvl;
		logic                                         sda_oe;
		logic [`DWSB_POTS-1:0][`DWSB_WIPER_W-1:0]     wiper;
		logic [`DWSB_POTS-1:0][`DWSB_SLOTS-1:0][`DWSB_WIPER_W-1:0] stored;
	} dwsb_sys_s;

	typedef struct packed {
		logic [7:0] shift;
	} dwsb_link_s;

endpackage

// File: rtl/dwsb_sync.sv
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs are static or slow against the clock
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
`include "dwsb_map.svh"
module dwsb_sync #(
	parameter int unsigned W = 1
)(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         ce_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	import dwsb_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dwsb_sync_s;

	dwsb_sync_s sync_r;
	dwsb_sync_s sync_nxt;

	if (W < 1) begin : g_chk
		$error("dwsb_sync: W must be at least 1");
	end

	always_comb begin
		sync_nxt    = sync_r;
		sync_nxt.s1 = d_in;
		sync_nxt.s2 = sync_r.s1;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_r <= '0;
		end else if (ce_in) begin
			sync_r <= sync_nxt;
		end
	end

	assign q_out = sync_r.s2;
endmodule // dwsb_sync

// File: rtl/dwsb_tap_decode.sv
// Purpose: One-hot tap switch select from a wiper position
// Assumes: Position below TAPS
// Notes:   Registered so exactly one switch closes at any time
`timescale 1ns/1ps
`include "dwsb_map.svh"
module dwsb_tap_decode #(
	parameter int unsigned W    = `DWSB_WIPER_W,
	parameter int unsigned TAPS = `DWSB_TAPS
)(
	input  wire logic            clk_in,
	input  wire logic            rst_in,
	input  wire logic            ce_in,
	input  wire logic [W-1:0]    pos_in,
	output logic      [TAPS-1:0] tap_out
);
	import dwsb_pkg::*;

	typedef struct packed {
		logic [TAPS-1:0] onehot;
	} dwsb_dec_s;

	dwsb_dec_s dec_r;
	dwsb_dec_s dec_nxt;

	if (TAPS > (1 << W) || TAPS < 2) begin : g_chk
		$error("dwsb_tap_decode: TAPS does not fit the position width");
	end

	always_comb begin
		dec_nxt                = dec_r;
		dec_nxt.onehot         = '0;
		dec_nxt.onehot[pos_in] = 1'b1;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dec_r <= '{onehot: TAPS'(1)};
		end else if (ce_in) begin
			dec_r <= dec_nxt;
		end
	end

	assign tap_out = dec_r.onehot;
endmodule // dwsb_tap_decode

// File: rtl/dwsb_top.sv
// Purpose: Serial slave and setting bank for two 64-tap wipers
// Assumes: Master drives SCL; SDA wire resolved outside
// Notes:   Stored settings are flops preset from STORED_INIT
//
// Summary of operation
// - Independent 6-bit wiper register per pot
// - 64 taps addressed by wiper value
// - Exactly one tap closed per pot
// - Four 6-bit stored settings per pot
// - Power-up copies first stored setting to wiper
// - Master reads and writes wipers and settings
// - Instructions move settings between wiper and slots
// - Instruction enters step up/down mode
// - Respond only when address pins match
// - SDA driven as open drain only
// - SCL times every transfer
`timescale 1ns/1ps
`include "dwsb_map.svh"
module dwsb_top #(
	parameter logic [2:0]  DEV_TYPE    = 3'h2, // Arbitrary value
	parameter logic [5:0]  STORED_INIT = 6'h20
)(
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_in,
	input  wire logic                 ce_in,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	input  wire logic                 addr_select_bit0_in,
	input  wire logic                 addr_select_bit1_in,
	input  wire logic                 addr_select_bit2_in,
	input  wire logic                 addr_select_bit3_in,
	output logic                      sda_out_out,
	output logic                      sda_oe_out,
	output dwsb_pkg::dwsb_wiper_t     wiper_position_register0_out,
	output dwsb_pkg::dwsb_wiper_t     wiper_position_register1_out,
	output dwsb_pkg::dwsb_tap_t       tap_sel0_out,
	output dwsb_pkg::dwsb_tap_t       tap_sel1_out
);
	import dwsb_pkg::*;

	localparam int unsigned SYNC_W = 6;

	// ----------------------------------------------------------------
	// Reset image
	// ----------------------------------------------------------------
	localparam dwsb_sys_s SYS_RST = '{
		state:   ST_IDLE,
		bit_cnt: 4'h0,
		scl_d:   1'b1,
		sda_d:   1'b1,
		boot:    1'b1,
		cmd:     8'h00,
		tx:      8'h00,
		sda_lvl: 1'b0,
		sda_oe:  1'b0,
		wiper:   '0,
		stored:  {(`DWSB_POTS * `DWSB_SLOTS){STORED_INIT}}
	};

	dwsb_sys_s  sys_r;
	dwsb_sys_s  sys_nxt;
	dwsb_link_s link_r;
	dwsb_link_s link_nxt;

	logic [SYNC_W-1:0]             sync_q;
	logic                          scl_s;
	logic                          sda_s;
	logic [3:0]                    addr_s;
	logic                          rise;
	logic                          fall;
	logic                          start;
	logic                          stop;
	logic                          active;
	logic [7:0]                    rx_byte;
	logic [2:0]                    rx_op;
	logic                          rx_pot;
	logic [`DWSB_SLOT_W-1:0]       rx_slot;
	logic [2:0]                    cur_op;
	logic                          cur_pot;
	logic [`DWSB_SLOT_W-1:0]       cur_slot;
	logic                          addr_hit;
	dwsb_wiper_t                   rd_val;
	dwsb_wiper_t                   cur_wiper;
	dwsb_tap_t [`DWSB_POTS-1:0]    taps;

	// ----------------------------------------------------------------
	// Link side: SCL clocks the receive shifter
	// ----------------------------------------------------------------
	always_comb begin
		link_nxt       = link_r;
		link_nxt.shift = {link_r.shift[6:0], sda_in};
	end

	// Shifter is left free of ce_in: that enable lives in the other domain
	always_ff @(posedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			link_r <= '0;
		end else begin
			link_r <= link_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	dwsb_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_in (sys_clk_in),
		.rst_in (rst_in),
		.ce_in  (ce_in),
		.d_in   ({addr_select_bit3_in, addr_select_bit2_in,
		          addr_select_bit1_in, addr_select_bit0_in, sda_in, scl_in}),
		.q_out  (sync_q)
	);

	assign scl_s  = sync_q[0];
	assign sda_s  = sync_q[1];
	assign addr_s = sync_q[5:2];

	// ----------------------------------------------------------------
	// Bus event detection
	// ----------------------------------------------------------------
	assign rise   = scl_s & ~sys_r.scl_d;
	assign fall   = ~scl_s & sys_r.scl_d;
	assign start  = scl_s & sys_r.scl_d & sys_r.sda_d & ~sda_s;
	assign stop   = scl_s & sys_r.scl_d & ~sys_r.sda_d & sda_s;
	assign active = (sys_r.state == ST_ADDR) || (sys_r.state == ST_CMD) ||
	                (sys_r.state == ST_DATA) || (sys_r.state == ST_TX);

	// Shifter only moves on SCL rise; sampled after the synced fall it is
	// long stable, so the synced SCL level qualifies the word crossing
	assign rx_byte  = link_r.shift;
	assign rx_op    = rx_byte[`DWSB_OP_HI:`DWSB_OP_LO];
	assign rx_pot   = rx_byte[`DWSB_POT_BIT];
	assign rx_slot  = rx_byte[`DWSB_SLOT_HI:`DWSB_SLOT_LO];
	assign cur_op   = sys_r.cmd[`DWSB_OP_HI:`DWSB_OP_LO];
	assign cur_pot  = sys_r.cmd[`DWSB_POT_BIT];
	assign cur_slot = sys_r.cmd[`DWSB_SLOT_HI:`DWSB_SLOT_LO];

	assign addr_hit = (rx_byte[`DWSB_TYPE_HI:`DWSB_TYPE_LO] == DEV_TYPE) &&
	                  (rx_byte[`DWSB_PINS_HI:`DWSB_PINS_LO] == addr_s);

	assign cur_wiper = sys_r.wiper[cur_pot];
	assign rd_val    = (cur_op == `DWSB_OP_RD_STORED) ?
	                   sys_r.stored[cur_pot][cur_slot] : cur_wiper;

	// ----------------------------------------------------------------
	// Protocol engine and setting bank
	// ----------------------------------------------------------------
	always_comb begin
		sys_nxt       = sys_r;
		sys_nxt.scl_d = scl_s;
		sys_nxt.sda_d = sda_s;

		if (sys_r.boot) begin
			for (int p = 0; p < `DWSB_POTS; p++) begin
				sys_nxt.wiper[p] = sys_r.stored[p][0];
			end
			sys_nxt.boot = 1'b0;
		end

		if (stop) begin
			sys_nxt.state  = ST_IDLE;
			sys_nxt.sda_oe = 1'b0;
		end else if (start) begin
			sys_nxt.state   = ST_ADDR;
			sys_nxt.bit_cnt = 4'h0;
			sys_nxt.sda_oe  = 1'b0;
		end else if (active && rise) begin
			if (sys_r.bit_cnt == `DWSB_BIT_ACK) begin
				sys_nxt.bit_cnt = 4'h0;
				if (sys_r.state == ST_TX) begin
					if (sda_s) begin
						// Master declined further bytes
						sys_nxt.state = ST_WAIT;
					end else begin
						sys_nxt.tx = {2'b00, rd_val};
					end
				end
			end else begin
				sys_nxt.bit_cnt = sys_r.bit_cnt + 4'h1;
			end
		end else if (active && fall) begin
			if (sys_r.bit_cnt == `DWSB_BIT_ACK) begin
				sys_nxt.sda_oe = 1'b0;
				case (sys_r.state)
					ST_ADDR: begin
						if (!addr_hit) begin
							sys_nxt.state = ST_WAIT;
						end else if (rx_byte[`DWSB_RW_BIT]) begin
							sys_nxt.state  = ST_TX;
							sys_nxt.tx     = {2'b00, rd_val};
							sys_nxt.sda_oe = 1'b1;
						end else begin
							sys_nxt.state  = ST_CMD;
							sys_nxt.sda_oe = 1'b1;
						end
					end
					ST_CMD: begin
						sys_nxt.cmd = rx_byte;
						case (rx_op)
							`DWSB_OP_RECALL: begin
								sys_nxt.wiper[rx_pot] =
									sys_r.stored[rx_pot][rx_slot];
							end
							`DWSB_OP_SAVE: begin
								sys_nxt.stored[rx_pot][rx_slot] =
									sys_r.wiper[rx_pot];
							end
							default: begin
							end
						endcase
						if (rx_op == `DWSB_OP_RSVD) begin
							sys_nxt.state = ST_WAIT;
						end else begin
							sys_nxt.state  = ST_DATA;
							sys_nxt.sda_oe = 1'b1;
						end
					end
					ST_DATA: begin
						sys_nxt.sda_oe = 1'b1;
						case (cur_op)
							`DWSB_OP_WR_WIPER: begin
								sys_nxt.wiper[cur_pot] =
									rx_byte[`DWSB_WIPER_W-1:0];
							end
							`DWSB_OP_WR_STORED: begin
								sys_nxt.stored[cur_pot][cur_slot] =
									rx_byte[`DWSB_WIPER_W-1:0];
							end
							`DWSB_OP_INCDEC: begin
								// Saturating steps keep the wiper from wrapping end to end
								if (rx_byte[`DWSB_STEP_BIT]) begin
									if (cur_wiper != `DWSB_WIPER_MAX) begin
										sys_nxt.wiper[cur_pot] = cur_wiper + 6'h01;
									end
								end else begin
									if (cur_wiper != `DWSB_WIPER_MIN) begin
										sys_nxt.wiper[cur_pot] = cur_wiper - 6'h01;
									end
								end
							end
							default: begin
								// No data byte belongs to this command
								sys_nxt.state  = ST_WAIT;
								sys_nxt.sda_oe = 1'b0;
							end
						endcase
					end
					default: begin
					end
				endcase
			end else if (sys_r.state == ST_TX) begin
				sys_nxt.sda_oe =
					~sys_r.tx[`DWSB_BIT_MSB - sys_r.bit_cnt[2:0]];
			end else begin
				sys_nxt.sda_oe = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sys_r <= SYS_RST;
		end else if (ce_in) begin
			sys_r <= sys_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Tap switch decode
	// ----------------------------------------------------------------
	for (genvar p = 0; p < `DWSB_POTS; p++) begin : g_pot
		dwsb_tap_decode #(
			.W    (`DWSB_WIPER_W),
			.TAPS (`DWSB_TAPS)
		) u_dec (
			.clk_in  (sys_clk_in),
			.rst_in  (rst_in),
			.ce_in   (ce_in),
			.pos_in  (sys_r.wiper[p]),
			.tap_out (taps[p])
		);
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sda_out_out                  = sys_r.sda_lvl;
	assign sda_oe_out                   = sys_r.sda_oe;
	assign wiper_position_register0_out = sys_r.wiper[0];
	assign wiper_position_register1_out = sys_r.wiper[1];
	assign tap_sel0_out                 = taps[0];
	assign tap_sel1_out                 = taps[1];
endmodule // dwsb_top

// File: test/dwsb_bus_master.sv
// Purpose: Serial bus master model
// Assumes: SDA wire has a pull-up in the bench
// Notes:   SCL parks high between frames
`timescale 1ns/1ps
module dwsb_bus_master (
	input  wire logic lclk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge lclk_in);
	endtask
	// ----
	// Bit and frame timing
	// ----
	// SDA moves mid low phase, far from either SCL edge
	task automatic bitx(input logic b, output logic s);
		w(2);
		sda_low_out = !b;
		w(2);
		scl_out = 1'b1;
		w(4);
		s = sda_in;
		scl_out = 1'b0;
	endtask
	task automatic start();
		w(2);
		sda_low_out = 1'b0;
		w(2);
		scl_out = 1'b1;
		w(4);
		sda_low_out = 1'b1;
		w(4);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		w(2);
		sda_low_out = 1'b1;
		w(2);
		scl_out = 1'b1;
		w(4);
		sda_low_out = 1'b0;
		w(4);
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], s);
		end
		bitx(1'b1, s);
		ack = !s;
	endtask
	task automatic rd(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			d[i] = s;
		end
		bitx(!mack, s);
	endtask
endmodule // dwsb_bus_master

// File: test/dwsb_monitor.sv
// Purpose: Port checker for the wiper bank
// Assumes: Bench holds ce_in high
// Notes:   Bound to dwsb_top below
`timescale 1ns/1ps
module dwsb_monitor #(
	parameter logic [5:0] STORED_INIT = 6'h20
)(
	input wire logic                  sys_clk_in,
	input wire logic                  rst_in,
	input wire logic                  ce_in,
	input wire logic                  scl_in,
	input wire logic                  sda_out_out,
	input wire logic                  sda_oe_out,
	input wire dwsb_pkg::dwsb_wiper_t wiper_position_register0_out,
	input wire dwsb_pkg::dwsb_wiper_t wiper_position_register1_out,
	input wire dwsb_pkg::dwsb_tap_t   tap_sel0_out,
	input wire dwsb_pkg::dwsb_tap_t   tap_sel1_out
);
	import dwsb_pkg::*;
	wire dwsb_wiper_t w0 = wiper_position_register0_out;
	wire dwsb_wiper_t w1 = wiper_position_register1_out;
	wire dwsb_tap_t   t0 = tap_sel0_out;
	wire dwsb_tap_t   t1 = tap_sel1_out;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_open_drain: assert property (sda_out_out == 1'b0)
		else $error("sda data level not low");
	a_reset_state: assert property (disable iff (1'b0) rst_in |->
		!sda_oe_out && w0 == 6'h00 && w1 == 6'h00 && t0 == 64'h1)
		else $error("outputs not at reset values");
	a_boot_copy: assert property ($fell(rst_in) |->
		##[1:2] (w0 == STORED_INIT && w1 == STORED_INIT))
		else $error("stored slot 0 not copied at boot");
	a_tap_follow: assert property ($past(ce_in) |->
		t0 == (64'h1 << $past(w0)) && t1 == (64'h1 << $past(w1)))
		else $error("tap select not one cycle behind wiper");
	a_one_tap: assert property ($onehot(t0) && $onehot(t1))
		else $error("tap select not one hot");
	a_oe_scl_low: assert property ($changed(sda_oe_out) |->
		!scl_in && !$past(scl_in))
		else $error("sda enable moved while clock high");
	a_ack_hold: assert property ($rose(sda_oe_out) |-> !scl_in [*4])
		else $error("clock rose right after sda pulled low");
	a_wiper_scl: assert property (($changed(w0) || $changed(w1)) && !$past(rst_in, 2) |->
		!scl_in)
		else $error("wiper moved while clock high");
	a_pots_apart: assert property ($changed(w0) && $changed(w1) |-> $past(rst_in, 2))
		else $error("both wipers moved together");
endmodule // dwsb_monitor

bind dwsb_top dwsb_monitor #(.STORED_INIT(STORED_INIT)) u_monitor (
	.sys_clk_in, .rst_in, .ce_in, .scl_in, .sda_out_out, .sda_oe_out,
	.wiper_position_register0_out, .wiper_position_register1_out,
	.tap_sel0_out, .tap_sel1_out
);

// File: test/tb_dwsb_top.sv
// Purpose: Bench for the dual wiper setting bank
// Assumes: Bus master model drives SCL and SDA
// Notes:   Type code and stored init chosen here
`timescale 1ns/1ps
module tb_dwsb_top;
	import dwsb_pkg::*;
	localparam logic [2:0] DT  = 3'h5; // Arbitrary value
	localparam logic [5:0] SI  = 6'h2b;
	localparam logic [7:0] ADR = {DT, 4'h2, 1'b0};
	logic        sys_clk = 1'b1;
	logic        lclk    = 1'b0;
	logic        rst     = 1'b0;
	logic [3:0]  pins    = 4'h2;
	logic        scl, m_low, oe, sd_o, sda, a_a, a_c, a_d;
	logic [7:0]  rv;
	dwsb_wiper_t w0, w1;
	dwsb_tap_t   t0, t1;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cyc = 0;
	// Pull-up wins unless someone pulls low
	assign sda = (oe ? sd_o : 1'b1) & !m_low;

	initial begin
		forever #2 sys_clk = !sys_clk;
	end
	initial begin
		#3;
		forever #6 lclk = !lclk;
	end

	dwsb_top #(.DEV_TYPE(DT), .STORED_INIT(SI)) i_dwsb_top (
		.sys_clk_in(sys_clk), .rst_in(rst), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
		.addr_select_bit0_in(pins[0]), .addr_select_bit1_in(pins[1]),
		.addr_select_bit2_in(pins[2]), .addr_select_bit3_in(pins[3]),
		.sda_out_out(sd_o), .sda_oe_out(oe),
		.wiper_position_register0_out(w0), .wiper_position_register1_out(w1),
		.tap_sel0_out(t0), .tap_sel1_out(t1)
	);
	dwsb_bus_master bm (.lclk_in(lclk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));

	// ----
	// Compare and bus tasks
	// ----
	task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_t(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cmdw(input logic [7:0] c, input logic [7:0] d, input int n);
		bm.start();
		bm.wr(ADR, a_a);
		bm.wr(c, a_c);
		repeat (n) bm.wr(d, a_d);
		bm.stop();
		@(negedge sys_clk);
	endtask
	task automatic rdr(input logic [7:0] c);
		bm.start();
		bm.wr(ADR, a_a);
		bm.wr(c, a_c);
		bm.start();
		bm.wr(ADR | 8'h01, a_a);
		bm.rd(1'b0, rv);
		bm.stop();
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk_v({2'h0, w0}, {2'h0, SI});
		chk_v({2'h0, w1}, {2'h0, SI});
		chk_t(t1, 64'h1 << SI);
		cmdw(8'h00, 8'h15, 1);
		chk_b(a_a, 1'b1);
		chk_b(a_d, 1'b1);
		chk_v({2'h0, w0}, 8'h15);
		chk_v({2'h0, w1}, {2'h0, SI});
		chk_t(t0, 64'h0000_0000_0020_0000);
		cmdw(8'h58, 8'h2a, 1);
		rdr(8'h78);
		chk_v(rv, 8'h2a);
		cmdw(8'h98, 8'h00, 1);
		chk_b(a_d, 1'b0);
		chk_v({2'h0, w1}, 8'h2a);
		cmdw(8'hac, 8'h00, 0);
		rdr(8'h6c);
		chk_v(rv, 8'h15);
		rdr(8'h20);
		chk_v(rv, 8'h15);
		cmdw(8'h00, 8'h3e, 1);
		cmdw(8'hc0, 8'h01, 2);
		chk_v({2'h0, w0}, 8'h3f);
		cmdw(8'hc0, 8'h00, 1);
		chk_v({2'h0, w0}, 8'h3e);
		cmdw(8'he0, 8'h05, 1);
		chk_b(a_c, 1'b0);
		pins = 4'h3;
		repeat (4) @(negedge sys_clk);
		cmdw(8'h00, 8'h07, 1);
		chk_b(a_a, 1'b0);
		chk_v({2'h0, w0}, 8'h3e);
		wrap_up();
	end
endmodule // tb_dwsb_top
